// ==== bench/picr_regs_tb.sv ====
/*
 * Self-checking bench of the posted clear/post registers.
 * Assumes the design answers each Wishbone cycle with one ack.
 */
`timescale 1ns/1ns
module picr_regs_tb;
    import picr_pkg::*;
    typedef struct packed {
        logic [7:0] idx;
        logic en;
        logic [7:0] w;
        logic [7:0] exp;
    } picr_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic ack;
    logic [23:0] raise_req = '0;
    logic [23:0] take_req = '0;
    logic [23:0] raise;
    logic [23:0] taken;
    logic [23:0] pending;
    logic swen;
    logic irq;
    logic [31:0] q;
    logic [3:0] sel = 4'h1;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    picr_row_t rows [9] = '{
        '{8'hDA, 1'b1, 8'hFF, 8'hFF},
        '{8'hDA, 1'b1, 8'h00, 8'hFF},
        '{8'hDA, 1'b0, 8'hFF, 8'hFF},
        '{8'hDA, 1'b0, 8'h0F, 8'h0F},
        '{8'hDA, 1'b0, 8'h00, 8'h00},
        '{8'hDB, 1'b1, 8'hA5, 8'hA5},
        '{8'hDB, 1'b0, 8'h00, 8'h00},
        '{8'hDC, 1'b1, 8'h3F, 8'h3F},
        '{8'hDC, 1'b0, 8'h00, 8'h00}
    };

    picr_src_model u_src (.clk_i(clk_i), .raise_req_i(raise_req), .take_req_i(take_req),
        .raise_o(raise), .taken_o(taken));
    picr_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .src_raise_i(raise), .src_taken_i(taken), .pending_o(pending),
        .software_interrupt_enable_o(swen), .irq_o(irq));

    // Clock and hang guard
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // One classic cycle; read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        tick(4);
        rst_i <= 1'b0;
        tick(1);
        chk({pending, swen, irq}, 26'h0);
        for (int i = 0; i < 9; i++) begin
            wb(1'b0, (i < 3) ? 8'hDA + i : 8'hDD + i, 8'h00);
            chk(q, 8'h00);
        end
        foreach (rows[i]) begin
            wb(1'b1, PICR_IDX_CTRL, {7'h0, rows[i].en});
            wb(1'b1, rows[i].idx, rows[i].w);
            wb(1'b0, rows[i].idx, 8'h00);
            chk(q, rows[i].exp);
            chk(pending[(rows[i].idx - 8'hDA) * 8 +: 8], rows[i].exp);
            chk(swen, rows[i].en);
        end
        // Clearing nothing raises no clear event
        wb(1'b1, PICR_IDX_EV_STAT, 8'h0F);
        wb(1'b1, 8'hDA, 8'h00);
        wb(1'b0, PICR_IDX_EV_STAT, 8'h00);
        chk(q, 8'h00);
        // Hardware raise joins the posted set, unmasked to irq
        wb(1'b1, PICR_IDX_EV_MASK, 8'h04);
        raise_req <= 24'h000008;
        tick(1);
        raise_req <= '0;
        tick(3);
        chk({pending, irq}, 25'h000011);
        wb(1'b0, 8'hDA, 8'h00);
        chk(q, 8'h08);
        take_req <= 24'h000008;
        tick(1);
        take_req <= '0;
        tick(3);
        chk(pending, 24'h0);
        // Mask, unmask and acknowledge the event
        wb(1'b1, PICR_IDX_EV_MASK, 8'h00);
        tick(2);
        chk(irq, 1'b0);
        wb(1'b1, PICR_IDX_EV_MASK, 8'h04);
        tick(2);
        chk(irq, 1'b1);
        wb(1'b1, PICR_IDX_EV_STAT, 8'h04);
        tick(2);
        chk(irq, 1'b0);
        // Unmapped place and a forbidden reserved write
        wb(1'b0, 8'h10, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, 8'hDC, 8'hC0);
        wb(1'b0, 8'hDC, 8'h00);
        chk(q, 8'h00);
        wb(1'b0, PICR_IDX_EV_STAT, 8'h00);
        chk(q, 8'h08);
        // Write with its byte lane off is ignored
        wb(1'b1, PICR_IDX_CTRL, 8'h01);
        sel <= 4'h0;
        wb(1'b1, 8'hDA, 8'h55);
        sel <= 4'h1;
        wb(1'b0, 8'hDA, 8'h00);
        chk(q, 8'h00);
        // Mid-run reset drops every posted flag and register
        wb(1'b1, 8'hDA, 8'h55);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(1);
        chk({pending, swen, irq}, 26'h0);
        wb(1'b0, PICR_IDX_EV_STAT, 8'h00);
        chk(q, 8'h00);
        tally_and_finish();
    end
endmodule : picr_regs_tb

// ==== bench/picr_src_model.sv ====
/*
 * Interrupt source model: turns raise and take requests into strobes.
 * Assumes the bench requests on rising edges of clk_i.
 */
`timescale 1ns/1ns
module picr_src_model
    import picr_pkg::*;
(
    input wire logic clk_i,
    input wire logic [PICR_SRC_N-1:0] raise_req_i,
    input wire logic [PICR_SRC_N-1:0] take_req_i,
    output logic [PICR_SRC_N-1:0] raise_o = '0,
    output logic [PICR_SRC_N-1:0] taken_o = '0
);
    // Strobes follow requests one edge later
    always_ff @(posedge clk_i) begin
        raise_o <= raise_req_i;
        taken_o <= take_req_i;
    end
endmodule : picr_src_model

// ==== core/picr_pkg.sv ====
/*
 * Constants and carrier types for the posted interrupt clear/post registers.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
package picr_pkg;

    // Bus geometry and source count
    localparam int unsigned PICR_ADR_W = 10;
    localparam int unsigned PICR_SRC_N = 24;

    // Register indices; byte address is four times the index
    localparam logic [7:0] PICR_IDX_CLEAR_0 = 8'hDA;
    localparam logic [7:0] PICR_IDX_CLEAR_1 = 8'hDB;
    localparam logic [7:0] PICR_IDX_CLEAR_2 = 8'hDC;
    localparam logic [7:0] PICR_IDX_CTRL = 8'hE0;
    localparam logic [7:0] PICR_IDX_EV_STAT = 8'hE1;
    localparam logic [7:0] PICR_IDX_EV_MASK = 8'hE2;

    // Field layout
    localparam logic [7:0] PICR_CLEAR_2_USED = 8'h3F;
    localparam int unsigned PICR_CTRL_SWEN = 0;
    localparam logic [7:0] PICR_RST_BYTE = 8'h00;

    // Event bits of the status and mask registers
    localparam int unsigned PICR_EV_POST = 0;
    localparam int unsigned PICR_EV_CLEAR = 1;
    localparam int unsigned PICR_EV_RAISE = 2;
    localparam int unsigned PICR_EV_RSVD = 3;
    localparam int unsigned PICR_EV_W = 4;

    // One write to the posted bank
    typedef struct packed {
        logic valid;
        logic swen;
        logic [PICR_SRC_N-1:0] lanes;
        logic [PICR_SRC_N-1:0] data;
    } picr_wcmd_t;

    // State of the register block apart from the bank's pending flags
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic swen;
        logic [PICR_EV_W-1:0] ev_stat;
        logic [PICR_EV_W-1:0] ev_mask;
        logic irq;
    } picr_state_t;

endpackage : picr_pkg

// ==== core/picr_post_bank.sv ====
/*
 * Pending flags of all interrupt sources, raised by hardware or software.
 * Assumes raise and taken strobes come from logic on the same clock.
 */
`timescale 1ns/1ns
module picr_post_bank
    import picr_pkg::*;
#(
    parameter int unsigned N = PICR_SRC_N
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire picr_wcmd_t wcmd_i,
    input wire logic [N-1:0] raise_i,
    input wire logic [N-1:0] taken_i,
    output logic [N-1:0] pending_o,
    output logic [N-1:0] cleared_o
);

    typedef struct packed {
        logic [N-1:0] pending;
    } picr_bank_t;

    picr_bank_t s;
    picr_bank_t next_s;
    logic [N-1:0] set_v;
    logic [N-1:0] clr_v;

    // Software and hardware share one pending set; any set beats any clear
    always_comb begin
        next_s = s;
        set_v = {N{wcmd_i.valid & wcmd_i.swen}} & wcmd_i.lanes & wcmd_i.data;
        clr_v = {N{wcmd_i.valid & ~wcmd_i.swen}} & wcmd_i.lanes & ~wcmd_i.data;
        next_s.pending = (s.pending & ~(clr_v | taken_i)) | set_v | raise_i;
        cleared_o = s.pending & clr_v & ~set_v & ~raise_i;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pending_o = s.pending;

endmodule : picr_post_bank

// ==== core/picr_regs.sv ====
/*
 * Wishbone register front end of the posted interrupt clear/post registers,
 * with the software enable, an event status/mask pair and one interrupt line.
 * Assumes a classic Wishbone master on clk_i and source strobes on clk_i.
 */
`timescale 1ns/1ns

module picr_regs
    import picr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PICR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PICR_SRC_N-1:0] src_raise_i,
    input wire logic [PICR_SRC_N-1:0] src_taken_i,
    output logic [PICR_SRC_N-1:0] pending_o,
    output logic software_interrupt_enable_o,
    output logic irq_o
);

    picr_state_t s;
    picr_state_t next_s;
    picr_wcmd_t wcmd;
    logic [PICR_SRC_N-1:0] pend;
    logic [PICR_SRC_N-1:0] cleared;
    logic [7:0] idx;
    logic req;
    logic fire;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;
    logic [PICR_EV_W-1:0] ev_set;
    logic [PICR_EV_W-1:0] ev_w1c;
    logic [PICR_SRC_N-1:0] raise_used;
    logic [PICR_SRC_N-1:0] taken_used;

    // Sources 23..22 have no register bit; keep them out of the pending set
    assign raise_used = {2'b00, src_raise_i[21:0]};
    assign taken_used = {2'b00, src_taken_i[21:0]};

    assign idx = wb_adr_i[PICR_ADR_W-1:2];
    assign req = wb_cyc_i & wb_stb_i;

    // Write lands on the edge where the master sees ack
    assign fire = req & s.ack & wb_we_i & wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    // Read mux; reserved and unmapped bits read zero
    always_comb begin
        rd_byte = PICR_RST_BYTE;
        unique case (idx)
            PICR_IDX_CLEAR_0: rd_byte = pend[7:0];
            PICR_IDX_CLEAR_1: rd_byte = pend[15:8];
            PICR_IDX_CLEAR_2: rd_byte = {2'b00, pend[21:16]};
            PICR_IDX_CTRL: rd_byte = {7'h00, s.swen};
            PICR_IDX_EV_STAT: rd_byte = {4'h0, s.ev_stat};
            PICR_IDX_EV_MASK: rd_byte = {4'h0, s.ev_mask};
            default: rd_byte = PICR_RST_BYTE;
        endcase
    end

    // Write command to the pending bank, one byte lane per register
    always_comb begin
        wcmd.valid = 1'b0;
        wcmd.swen = s.swen;
        wcmd.lanes = '0;
        wcmd.data = '0;
        if (fire) begin
            unique case (idx)
                PICR_IDX_CLEAR_0: begin
                    wcmd.valid = 1'b1;
                    wcmd.lanes[7:0] = 8'hFF;
                    wcmd.data[7:0] = wr_byte;
                end
                PICR_IDX_CLEAR_1: begin
                    wcmd.valid = 1'b1;
                    wcmd.lanes[15:8] = 8'hFF;
                    wcmd.data[15:8] = wr_byte;
                end
                PICR_IDX_CLEAR_2: begin
                    wcmd.valid = 1'b1;
                    wcmd.lanes[21:16] = PICR_CLEAR_2_USED[5:0];
                    wcmd.data[21:16] = wr_byte[5:0];
                end
                default: wcmd.valid = 1'b0;
            endcase
        end
    end

    // Pending flags of all sources
    picr_post_bank #(
        .N(PICR_SRC_N)
    ) u_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wcmd_i(wcmd),
        .raise_i(raise_used),
        .taken_i(taken_used),
        .pending_o(pend),
        .cleared_o(cleared)
    );

    // Events seen by the block's own interrupt
    always_comb begin
        ev_set = '0;
        ev_set[PICR_EV_POST] = wcmd.valid & s.swen & |(wcmd.lanes & wcmd.data);
        ev_set[PICR_EV_CLEAR] = |cleared;
        ev_set[PICR_EV_RAISE] = |raise_used;
        ev_set[PICR_EV_RSVD] = fire & (idx == PICR_IDX_CLEAR_2) & |(wr_byte & ~PICR_CLEAR_2_USED);
        ev_w1c = '0;
        if (fire && idx == PICR_IDX_EV_STAT) begin
            ev_w1c = wr_byte[PICR_EV_W-1:0];
        end
    end

    // Bus handshake, control registers and interrupt line
    always_comb begin
        next_s = s;
        next_s.ack = req & ~s.ack;
        if (req && !s.ack) begin
            next_s.rdata = {24'h000000, rd_byte};
        end
        if (fire && idx == PICR_IDX_CTRL) begin
            next_s.swen = wr_byte[PICR_CTRL_SWEN];
        end
        if (fire && idx == PICR_IDX_EV_MASK) begin
            next_s.ev_mask = wr_byte[PICR_EV_W-1:0];
        end
        // Set wins over a clear in the same cycle
        next_s.ev_stat = (s.ev_stat & ~ev_w1c) | ev_set;
        next_s.irq = |(next_s.ev_stat & next_s.ev_mask);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign pending_o = pend;
    assign software_interrupt_enable_o = s.swen;
    assign irq_o = s.irq;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Request seen, then answered
    sequence s_req_new;
        req && !s.ack;
    endsequence

    sequence s_answer;
        ##1 wb_ack_o;
    endsequence

    a_bus_ack_once: assert property (s_req_new |-> s_answer ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    a_read_posted_state: assert property (
        (s_req_new and (!wb_we_i && idx == PICR_IDX_CLEAR_0))
        |=> wb_dat_o[7:0] == $past(pend[7:0]))
        else $error("clear register read does not show posted state");

    a_clear_when_off: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_0 && !wr_byte[0] && !src_raise_i[0]
        |=> !pend[0])
        else $error("zero write did not clear posted interrupt");

    a_clear_noop_quiet: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_0 && pend == '0
        |=> !$rose(s.ev_stat[PICR_EV_CLEAR]))
        else $error("clear of nothing produced an event");

    a_post_when_on: assert property (
        fire && s.swen && idx == PICR_IDX_CLEAR_1 && wr_byte[0]
        |=> pend[8])
        else $error("one write did not post interrupt");

    a_post_ignored_off: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_1 && wr_byte[0]
        && !pend[8] && !src_raise_i[8]
        |=> !pend[8])
        else $error("one write posted while enable clear");

    a_no_clear_on: assert property (
        fire && s.swen && idx == PICR_IDX_CLEAR_0 && !wr_byte[0]
        && pend[0] && !src_taken_i[0]
        |=> pend[0])
        else $error("zero write cleared while enable set");

    a_third_reg_bits: assert property (
        (s_req_new and (!wb_we_i && idx == PICR_IDX_CLEAR_2))
        |=> wb_dat_o[7:6] == 2'b00 && wb_dat_o[5:0] == $past(pend[21:16]))
        else $error("third register read wrong");

    a_rsvd_flagged: assert property (
        fire && idx == PICR_IDX_CLEAR_2 && wr_byte[7:6] != 2'b00
        |=> s.ev_stat[PICR_EV_RSVD])
        else $error("reserved write not flagged");

    a_hw_raise_joins: assert property (
        src_raise_i[16] |=> pend[16] ##0 s.ev_stat[PICR_EV_RAISE])
        else $error("hardware raise missing from pending set");

    a_irq_follows: assert property (
        s.ev_stat[PICR_EV_POST] && s.ev_mask[PICR_EV_POST] |-> irq_o)
        else $error("unmasked event without interrupt");

    // Read answer carries only the low byte
    a_read_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    // Ack only ever answers a request
    a_ack_has_req: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");

    a_second_reg_read: assert property (
        (s_req_new and (!wb_we_i && idx == PICR_IDX_CLEAR_1))
        |=> wb_dat_o[7:0] == $past(pend[15:8]))
        else $error("second register read does not show posted state");

    a_ctrl_read: assert property (
        (s_req_new and (!wb_we_i && idx == PICR_IDX_CTRL))
        |=> wb_dat_o[0] == $past(s.swen))
        else $error("enable read wrong");

    a_unmapped_zero: assert property (
        (s_req_new and (!wb_we_i && idx == 8'h10))
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");

    a_clear_second_reg: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_1 && !wr_byte[7] && !src_raise_i[15]
        |=> !pend[15])
        else $error("zero write did not clear second register bit");

    a_clear_event_real: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_0 && pend[0] && !wr_byte[0] && !src_raise_i[0]
        |=> s.ev_stat[PICR_EV_CLEAR])
        else $error("real clear gave no event");

    a_write_quiet_bank: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_1 && pend[15:8] == 8'h00 && src_raise_i[15:8] == 8'h00
        |=> pend[15:8] == 8'h00)
        else $error("clear of nothing changed state");

    a_post_event: assert property (
        fire && s.swen && idx == PICR_IDX_CLEAR_0 && wr_byte != 8'h00
        |=> s.ev_stat[PICR_EV_POST])
        else $error("post gave no event");

    a_swen_follows: assert property (
        fire && idx == PICR_IDX_CTRL
        |=> software_interrupt_enable_o == $past(wr_byte[PICR_CTRL_SWEN]))
        else $error("enable write not taken");

    a_post_ignored_first: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_0 && wr_byte[7]
        && !pend[7] && !src_raise_i[7]
        |=> !pend[7])
        else $error("one write posted first register while enable clear");

    a_no_clear_second: assert property (
        fire && s.swen && idx == PICR_IDX_CLEAR_1 && !wr_byte[7]
        && pend[15] && !src_taken_i[15]
        |=> pend[15])
        else $error("zero write cleared second register while enable set");

    a_post_third_reg: assert property (
        fire && s.swen && idx == PICR_IDX_CLEAR_2 && wr_byte[5]
        |=> pend[21])
        else $error("one write did not post third register bit");

    a_clear_third_reg: assert property (
        fire && !s.swen && idx == PICR_IDX_CLEAR_2 && !wr_byte[4] && !src_raise_i[20]
        |=> !pend[20])
        else $error("zero write did not clear third register bit");

    a_top_bits_zero: assert property (pend[23:22] == 2'b00)
        else $error("unmapped pending bits set");

    a_taken_clears: assert property (
        src_taken_i[8] && !src_raise_i[8]
        && !(fire && s.swen && idx == PICR_IDX_CLEAR_1 && wr_byte[0])
        |=> !pend[8])
        else $error("taken vector left pending");

    a_raise_event_set: assert property (
        |src_raise_i[21:0]
        |=> s.ev_stat[PICR_EV_RAISE])
        else $error("hardware raise gave no event");

    // A write with its byte lane off leaves the posted set alone
    a_sel_gates_write: assert property (
        req && s.ack && wb_we_i && !wb_sel_i[0] && idx == PICR_IDX_CLEAR_0
        && !src_raise_i[0] && !src_taken_i[0]
        |=> pend[0] == $past(pend[0]))
        else $error("write without byte lane took effect");

    // Writing one to a status bit clears it when no event sets it again
    a_w1c_clears: assert property (
        fire && idx == PICR_IDX_EV_STAT && wr_byte[PICR_EV_RSVD] && !ev_set[PICR_EV_RSVD]
        |=> !s.ev_stat[PICR_EV_RSVD])
        else $error("status bit not cleared by write of one");

endmodule : picr_regs
